// ### rtl/ext_bus_pin_mux.sv
// top: pin multiplexer of the external bus interface
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - each shared pin carries the line of the active controller
// - upper byte pin: dram mask 1, else static upper write/select
// - addr0/mask0 pin carries static address 0 or lower select
// - addr1/mask2 pin carries static address bit 1 only
// - pins 11..2 carry dram address 9..0, else static 11..2
// - dedicated addr10 pin carries dram address bit 10 only
// - address pin 12 carries static address bit 12 only
// - pins 14,13 carry dram address 12,11, else static 14,13
// - pins 22..15 carry static address bits only
// - data pins 31..16 used by the dram controller only
// - data pins 15..0 shared bit for bit by both
// - data bus 16 or 32 bits, address bus up to 23 bits
// - eight devices, each with its own chip select
// - dram clock enable active high, chip selects active low
// - chip select low selects, high otherwise
// - version query command then next read returns version
module ext_bus_pin_mux
	import ext_bus_pkg::*;
(
	input  wire logic                clk_sys_i,
	input  wire logic                rst_i,
	// static controller
	input  wire logic                st_active_i,
	input  wire logic [ADDR_W-1:0]   st_addr_i,
	input  wire logic [LOW_W-1:0]    st_wdata_i,
	input  wire logic                st_data_oe_i,
	input  wire logic [CS_W-1:0]     st_cs_n_i,
	input  wire logic [NWR_W-1:0]    st_nwr_i,
	input  wire logic                st_rd_n_i,
	input  wire logic                st_byte_mode_i,
	output logic [LOW_W-1:0]         st_rdata_o,
	output logic                     st_wait_o,
	// dram controller
	input  wire logic                dr_active_i,
	input  wire logic [SDR_ADDR_W-1:0] dr_addr_i,
	input  wire logic [DATA_W-1:0]   dr_wdata_i,
	input  wire logic                dr_data_oe_i,
	input  wire logic                dr_cs_n_i,
	input  wire logic [MASK_W-1:0]   dr_mask_n_i,
	input  wire logic                dr_cke_i,
	output logic [DATA_W-1:0]        dr_rdata_o,
	// programming interface
	input  wire logic                fpi_wr_i,
	input  wire logic [31:0]         fpi_wdata_i,
	input  wire logic                fpi_rd_i,
	output logic [31:0]              fpi_rdata_o,
	// external pins
	output logic [ADDR_W-1:0]        addr_o,
	output logic                     dram_addr10_pin_o,
	output logic [DATA_W-1:0]        data_o,
	output logic [DATA_W-1:0]        data_oe_o,
	input  wire logic [DATA_W-1:0]   data_i,
	output logic [CS_W-1:0]          chip_select_n_o,
	output logic                     lower_write_n_o,
	output logic                     read_strobe_n_o,
	output logic                     upper_byte_shared_pin_o,
	output logic                     upper_mask_n_o,
	output logic                     dram_clock_en_o,
	input  wire logic                wait_req_n_i
);
	////////////////////////////////////////////////////////////////////////
	owner_t owner;
	owner_t next_owner;
	logic   wait_meta;
	logic   wait_sync;
	logic [DATA_W-1:0] data_meta;
	logic [DATA_W-1:0] data_sync;
	logic   fpi_armed;

	ext_bus_ctrl_if st_bus ();
	ext_bus_ctrl_if dr_bus ();

	// dram owns the pins when both claim them; the arbiter above should
	// never let that happen, but a fixed choice keeps pins defined
	always_comb begin
		if (dr_bus.active) begin
			next_owner = OWN_DRAM;
		end else if (st_bus.active) begin
			next_owner = OWN_STATIC;
		end else begin
			next_owner = OWN_IDLE;
		end
	end

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			owner <= OWN_IDLE;
		end else begin
			owner <= next_owner;
		end
	end

	// gather each controller's lines into its carrier
	assign st_bus.active  = st_active_i;
	assign st_bus.addr    = st_addr_i;
	assign st_bus.wdata   = {16'h0000, st_wdata_i};
	assign st_bus.data_oe = {16'h0000, {LOW_W{st_data_oe_i}}};
	assign st_bus.cs_n    = st_cs_n_i;
	assign st_bus.nwr     = st_nwr_i;
	assign st_bus.rd_n    = st_rd_n_i;
	// upper select in 16-bit byte mode, upper write in dual 8-bit mode
	assign st_bus.mask_n  = {2'b11, st_byte_mode_i ? st_addr_i[0] : st_nwr_i[1],
		1'b1};
	assign st_bus.cke     = 1'b0;

	assign dr_bus.active  = dr_active_i;
	assign dr_bus.addr    = {10'h000, dr_addr_i};
	assign dr_bus.wdata   = dr_wdata_i;
	assign dr_bus.data_oe = {DATA_W{dr_data_oe_i}};
	assign dr_bus.cs_n    = {6'h3F, dr_cs_n_i, 1'b1}; // dram on select 1
	assign dr_bus.nwr     = 2'b11;
	assign dr_bus.rd_n    = 1'b1;
	assign dr_bus.mask_n  = dr_mask_n_i;
	assign dr_bus.cke     = dr_cke_i;

	////////////////////////////////////////////////////////////////////////
	// address pins
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			addr_o <= 23'h00_0000;
		end else begin
			case (next_owner)
				OWN_DRAM: begin
					addr_o <= {8'h00,
						dr_bus.addr[12:11],
						1'b0,
						dr_bus.addr[9:0],
						2'b00};
				end
				OWN_STATIC: begin
					// full 23-bit static address, lower select on pin 0
					addr_o <= {st_bus.addr[22:1],
						st_byte_mode_i ? 1'b0 : st_bus.addr[0]};
				end
				default: begin
					addr_o <= 23'h00_0000;
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			dram_addr10_pin_o <= 1'b0;
		end else begin
			dram_addr10_pin_o <= (next_owner == OWN_DRAM) ?
				dr_bus.addr[SDR_A10_POS] : 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// data pins
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			data_o    <= 32'h0000_0000;
			data_oe_o <= 32'h0000_0000;
		end else begin
			case (next_owner)
				OWN_DRAM: begin
					data_o    <= dr_bus.wdata;
					data_oe_o <= dr_bus.data_oe;
				end
				OWN_STATIC: begin
					data_o    <= st_bus.wdata;
					data_oe_o <= st_bus.data_oe;
				end
				default: begin
					data_o    <= 32'h0000_0000;
					data_oe_o <= 32'h0000_0000;
				end
			endcase
		end
	end

	// pins come from outside; two flops before any use
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			data_meta <= 32'h0000_0000;
			data_sync <= 32'h0000_0000;
			wait_meta <= 1'b1;
			wait_sync <= 1'b1;
		end else begin
			data_meta <= data_i;
			data_sync <= data_meta;
			wait_meta <= wait_req_n_i;
			wait_sync <= wait_meta;
		end
	end

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			st_rdata_o <= 16'h0000;
			dr_rdata_o <= 32'h0000_0000;
			st_wait_o  <= 1'b0;
		end else begin
			st_rdata_o <= data_sync[LOW_W-1:0];
			dr_rdata_o <= data_sync;
			st_wait_o  <= (owner == OWN_STATIC) && !wait_sync;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// strobes and selects
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			chip_select_n_o         <= 8'hFF;
			lower_write_n_o         <= 1'b1;
			read_strobe_n_o         <= 1'b1;
			upper_byte_shared_pin_o <= 1'b1;
			upper_mask_n_o          <= 1'b1;
			dram_clock_en_o         <= 1'b0;
		end else begin
			case (next_owner)
				OWN_DRAM: begin
					chip_select_n_o         <= dr_bus.cs_n;
					lower_write_n_o         <= dr_bus.nwr[0];
					read_strobe_n_o         <= dr_bus.rd_n;
					upper_byte_shared_pin_o <= dr_bus.mask_n[1];
					upper_mask_n_o          <= dr_bus.mask_n[3];
				end
				OWN_STATIC: begin
					chip_select_n_o         <= st_bus.cs_n;
					lower_write_n_o         <= st_bus.nwr[0];
					read_strobe_n_o         <= st_bus.rd_n;
					upper_byte_shared_pin_o <= st_bus.mask_n[1];
					upper_mask_n_o          <= 1'b1;
				end
				default: begin
					chip_select_n_o         <= 8'hFF;
					lower_write_n_o         <= 1'b1;
					read_strobe_n_o         <= 1'b1;
					upper_byte_shared_pin_o <= 1'b1;
					upper_mask_n_o          <= 1'b1;
				end
			endcase
			// cke follows the dram controller even while it is idle, so
			// self refresh survives static accesses
			dram_clock_en_o <= dr_bus.cke;
		end
	end

	////////////////////////////////////////////////////////////////////////
	version_query u_version (
		.clk_sys_i (clk_sys_i),
		.rst_i     (rst_i),
		.wr_i      (fpi_wr_i),
		.wdata_i   (fpi_wdata_i),
		.rd_i      (fpi_rd_i),
		.version_i (FPI_VERSION_RST),
		.armed_o   (fpi_armed),
		.rdata_o   (fpi_rdata_o)
	);

	////////////////////////////////////////////////////////////////////////
	a_dram_addr_map: assert property (
		@(posedge clk_sys_i) disable iff (rst_i)
		dr_active_i |=> addr_o[11:2] == $past(dr_addr_i[9:0])
			&& addr_o[14:13] == $past(dr_addr_i[12:11]))
		else $error("dram address not on pins");
	a_dram_a10_pin: assert property (
		@(posedge clk_sys_i) disable iff (rst_i)
		dr_active_i |=> dram_addr10_pin_o == $past(dr_addr_i[10]))
		else $error("dram address 10 pin wrong");
	a_dram_unused_low: assert property (
		@(posedge clk_sys_i) disable iff (rst_i)
		dr_active_i |=> addr_o[1:0] == 2'b00 && addr_o[22:15] == 8'h00
			&& !addr_o[12])
		else $error("dram drove static-only pin");
	a_static_addr_map: assert property (
		@(posedge clk_sys_i) disable iff (rst_i)
		st_active_i && !dr_active_i
			|=> addr_o[22:1] == $past(st_addr_i[22:1]))
		else $error("static address not on pins");
	a_static_upper_data: assert property (
		@(posedge clk_sys_i) disable iff (rst_i)
		st_active_i && !dr_active_i |=> data_oe_o[31:16] == 16'h0000)
		else $error("static drove upper data");
	a_upper_byte_pin: assert property (
		@(posedge clk_sys_i) disable iff (rst_i)
		dr_active_i |=> upper_byte_shared_pin_o == $past(dr_mask_n_i[1]))
		else $error("upper byte pin not dram mask 1");
	a_idle_pins_quiet: assert property (
		@(posedge clk_sys_i) disable iff (rst_i)
		!dr_active_i && !st_active_i |=> chip_select_n_o == 8'hFF
			&& read_strobe_n_o && lower_write_n_o)
		else $error("strobe active while idle");
	a_dram_no_static: assert property (
		@(posedge clk_sys_i) disable iff (rst_i)
		dr_active_i |=> read_strobe_n_o && lower_write_n_o)
		else $error("static strobe during dram access");
	a_wait_latency: assert property (
		@(posedge clk_sys_i) disable iff (rst_i)
		owner == OWN_STATIC && !wait_req_n_i ##1 owner == OWN_STATIC
			##1 owner == OWN_STATIC |=> st_wait_o)
		else $error("wait request not passed on");

	c_dram_access: cover property (@(posedge clk_sys_i) dr_active_i ##1 !dr_active_i);
	c_static_access: cover property (@(posedge clk_sys_i) st_active_i && !st_cs_n_i[0]);
	c_owner_switch: cover property (@(posedge clk_sys_i)
		owner == OWN_STATIC ##1 owner == OWN_DRAM);
	c_version_read: cover property (@(posedge clk_sys_i) fpi_armed && fpi_rd_i);
endmodule : ext_bus_pin_mux
`default_nettype wire

// ### rtl/ext_bus_pkg.sv
// package: constants and widths for the external bus pin multiplexer
package ext_bus_pkg;
	localparam int DATA_W        = 32;
	localparam int LOW_W         = 16;
	localparam int ADDR_W        = 23;
	localparam int CS_W          = 8;
	localparam int SDR_ADDR_W    = 13;
	localparam int NWR_W         = 2;
	localparam int MASK_W        = 4;
	// field positions on the shared address pins, and the dram address bit for the dedicated pin
	localparam int SDR_LO_BASE   = 2;
	localparam int SDR_HI_BASE   = 13;
	localparam int SDR_A10_POS   = 10;
	// version query
	localparam logic [31:0] VERSION_QUERY_CMD = 32'h0000_001E;
	localparam logic [31:0] FPI_VERSION_RST   = 32'h0000_0001;
	// owner of the external pins
	typedef enum logic [1:0] {OWN_IDLE, OWN_STATIC, OWN_DRAM} owner_t;
endpackage : ext_bus_pkg

// ### rtl/ext_bus_ctrl_if.sv
// interface: lines of one memory controller toward the pin multiplexer
`timescale 1ns/1ps
`default_nettype none
interface ext_bus_ctrl_if;
	logic        active;
	logic [22:0] addr;
	logic [31:0] wdata;
	logic [31:0] data_oe;
	logic [7:0]  cs_n;
	logic [1:0]  nwr;
	logic        rd_n;
	logic [3:0]  mask_n;
	logic        cke;
	modport ctrl (output active, addr, wdata, data_oe, cs_n, nwr, rd_n,
		mask_n, cke);
	modport mux  (input active, addr, wdata, data_oe, cs_n, nwr, rd_n,
		mask_n, cke);
endinterface : ext_bus_ctrl_if
`default_nettype wire

// ### rtl/version_query.sv
// version query responder for the fast programming interface
`timescale 1ns/1ps
`default_nettype none
module version_query
	import ext_bus_pkg::*;
(
	input  wire logic        clk_sys_i,
	input  wire logic        rst_i,
	input  wire logic        wr_i,
	input  wire logic [31:0] wdata_i,
	input  wire logic        rd_i,
	input  wire logic [31:0] version_i,
	output logic             armed_o,
	output logic [31:0]      rdata_o
);
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			armed_o <= 1'b0;
		end else if (wr_i) begin
			armed_o <= (wdata_i == VERSION_QUERY_CMD);
		end else if (rd_i) begin
			armed_o <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			rdata_o <= 32'h0000_0000;
		end else if (rd_i) begin
			// only the word right after the command returns the version
			rdata_o <= armed_o ? version_i : 32'h0000_0000;
		end
	end

	a_version_after_cmd: assert property (
		@(posedge clk_sys_i) disable iff (rst_i)
		armed_o && rd_i && !wr_i |=> rdata_o == $past(version_i))
		else $error("version not returned after query command");
endmodule : version_query
`default_nettype wire

// ### tb/mem_model.sv
// far-side memory model: answers reads on the data pins, may stretch
`timescale 1ns/1ps
`default_nettype none
module mem_model (
	input  wire logic        clk_sys_i,
	input  wire logic [7:0]  cs_n_i,
	input  wire logic        rd_n_i,
	input  wire logic        dram_i,
	input  wire logic [31:0] resp_i,
	input  wire logic        stretch_i,
	output logic [31:0]      data_o,
	output logic             wait_n_o
);
	logic        sel;
	logic [31:0] bus = 32'h0000_0000;
	assign sel = (&cs_n_i) == 1'b0;
	// a released bus toggles so a stale value can never pass for an answer
	always @(posedge clk_sys_i) begin
		if (sel && (!rd_n_i || dram_i))
			bus <= resp_i;
		else
			bus <= ~bus;
	end
	assign data_o = bus;
	assign wait_n_o = !(stretch_i && sel);
endmodule : mem_model
`default_nettype wire

// ### tb/ext_bus_pin_mux_tb.sv
// testbench: pin multiplexer of the external bus interface
`timescale 1ns/1ps
`default_nettype none
module ext_bus_pin_mux_tb;
	import ext_bus_pkg::*;
	logic clk_sys_i = 0, rst_i = 1, st_active_i = 0, st_data_oe_i = 0;
	logic st_rd_n_i = 1, st_byte_mode_i = 0, dr_active_i = 0;
	logic dr_data_oe_i = 0, dr_cs_n_i = 1, dr_cke_i = 0, fpi_wr_i = 0;
	logic fpi_rd_i = 0, stretch = 0, st_wait_o, a10, lw, rd, up, um, cke;
	logic [22:0] st_addr_i = 0, addr_o;
	logic [15:0] st_wdata_i = 0, st_rdata_o;
	logic [7:0]  st_cs_n_i = 8'hFF, cs_n;
	logic [1:0]  st_nwr_i = 2'h3;
	logic [12:0] dr_addr_i = 0;
	logic [3:0]  dr_mask_n_i = 4'hF;
	logic [31:0] dr_wdata_i = 0, fpi_wdata_i = 0, dr_rdata_o, fpi_rdata_o;
	logic [31:0] data_o, data_oe_o, data_i, resp = 0, r;
	logic        wait_n;
	int          bad_count = 0, checks_done = 0, seed_v;
	always #5 clk_sys_i = ~clk_sys_i;
	ext_bus_pin_mux uut (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
		.st_active_i(st_active_i), .st_addr_i(st_addr_i),
		.st_wdata_i(st_wdata_i), .st_data_oe_i(st_data_oe_i),
		.st_cs_n_i(st_cs_n_i), .st_nwr_i(st_nwr_i), .st_rd_n_i(st_rd_n_i),
		.st_byte_mode_i(st_byte_mode_i), .st_rdata_o(st_rdata_o),
		.st_wait_o(st_wait_o), .dr_active_i(dr_active_i),
		.dr_addr_i(dr_addr_i), .dr_wdata_i(dr_wdata_i),
		.dr_data_oe_i(dr_data_oe_i), .dr_cs_n_i(dr_cs_n_i),
		.dr_mask_n_i(dr_mask_n_i), .dr_cke_i(dr_cke_i),
		.dr_rdata_o(dr_rdata_o), .fpi_wr_i(fpi_wr_i),
		.fpi_wdata_i(fpi_wdata_i), .fpi_rd_i(fpi_rd_i),
		.fpi_rdata_o(fpi_rdata_o), .addr_o(addr_o),
		.dram_addr10_pin_o(a10), .data_o(data_o), .data_oe_o(data_oe_o),
		.data_i(data_i), .chip_select_n_o(cs_n), .lower_write_n_o(lw),
		.read_strobe_n_o(rd), .upper_byte_shared_pin_o(up),
		.upper_mask_n_o(um), .dram_clock_en_o(cke), .wait_req_n_i(wait_n));
	mem_model partner (.clk_sys_i(clk_sys_i), .cs_n_i(cs_n), .rd_n_i(rd),
		.dram_i(dr_active_i), .resp_i(resp), .stretch_i(stretch),
		.data_o(data_i), .wait_n_o(wait_n));
	////////////////////////////////////////////////////////////////////////
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			bad_count++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task print_verdict;
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : print_verdict
	// expectation from the inputs now held; the dram side wins a tie
	task check_pins;
		if (dr_active_i) begin
			chk("a11_2", 32'(dr_addr_i[9:0]), 32'(addr_o[11:2]));
			chk("a14_13", 32'(dr_addr_i[12:11]), 32'(addr_o[14:13]));
			chk("a10", 32'(dr_addr_i[10]), 32'(a10));
			chk("unused_a", 0, 32'({addr_o[22:15], addr_o[12],
				addr_o[1:0]}));
			chk("up", 32'(dr_mask_n_i[1]), 32'(up));
			chk("data", dr_wdata_i, data_o);
			chk("oe", {32{dr_data_oe_i}}, data_oe_o);
			chk("cs", 32'({6'h3F, dr_cs_n_i, 1'b1}), 32'(cs_n));
			chk("ctl", 32'({2'h3, dr_mask_n_i[3], dr_cke_i}),
				32'({lw, rd, um, cke}));
		end else if (st_active_i) begin
			chk("a22_2", 32'(st_addr_i[22:2]), 32'(addr_o[22:2]));
			chk("a1", 32'(st_addr_i[1]), 32'(addr_o[1]));
			chk("a0", 32'(st_addr_i[0] & !st_byte_mode_i), 32'(addr_o[0]));
			chk("up", 32'(st_byte_mode_i ? st_addr_i[0] : st_nwr_i[1]),
				32'(up));
			chk("data", 32'(st_wdata_i), 32'(data_o[15:0]));
			chk("oe", 32'({16{st_data_oe_i}}), data_oe_o);
			chk("cs", 32'(st_cs_n_i), 32'(cs_n));
			chk("ctl", 32'({st_nwr_i[0], st_rd_n_i, 2'h2, dr_cke_i}),
				32'({lw, rd, um, a10, cke}));
		end else begin
			chk("idle", 32'({8'hFF, 4'hF, 1'b0, dr_cke_i}),
				32'({cs_n, lw, rd, um, up, a10, cke}));
			chk("idle_a", 0, 32'(addr_o) | data_oe_o);
		end
	endtask : check_pins
	task fpi(input logic w, input logic [31:0] word, input logic [31:0] e);
		@(posedge clk_sys_i);
		fpi_wr_i <= w;
		fpi_rd_i <= !w;
		fpi_wdata_i <= word;
		@(posedge clk_sys_i);
		fpi_wr_i <= 0;
		fpi_rd_i <= 0;
		#1;
		if (!w)
			chk("fpi_rdata", e, fpi_rdata_o);
	endtask : fpi
	////////////////////////////////////////////////////////////////////////
	initial begin
		#50000;
		bad_count++;
		print_verdict();
	end
	initial begin
		repeat (20) @(posedge clk_sys_i);
		chk("rst", 32'({8'hFF, 4'hE}), 32'({cs_n, lw, rd, um, cke}));
		rst_i <= 0;
		seed_v = $urandom(36);
		for (int i = 0; i < 200; i++) begin
			@(posedge clk_sys_i);
			r = $urandom;
			// both controllers claim the pins: the dram side must win
			if (i < 4)
				r[2:1] = 2'h3;
			{st_active_i, dr_active_i, st_byte_mode_i} <= r[2:0];
			{st_data_oe_i, dr_data_oe_i, st_rd_n_i, dr_cs_n_i} <= r[6:3];
			{dr_cke_i, st_nwr_i, dr_mask_n_i} <= r[13:7];
			st_cs_n_i <= r[21:14];
			dr_addr_i <= r[31:19];
			st_addr_i <= 23'($urandom);
			st_wdata_i <= 16'($urandom);
			dr_wdata_i <= $urandom;
			@(posedge clk_sys_i);
			#1;
			check_pins();
		end
		for (int i = 0; i < 3; i++) begin
			@(posedge clk_sys_i);
			{st_active_i, dr_active_i, st_rd_n_i, dr_cs_n_i} <= 4'h9;
			st_cs_n_i <= 8'hFE;
			resp <= $urandom;
			stretch <= 1;
			repeat (8) @(posedge clk_sys_i);
			#1;
			chk("st_rdata", 32'(resp[15:0]), 32'(st_rdata_o));
			chk("st_wait", 1, 32'(st_wait_o));
			@(posedge clk_sys_i);
			{dr_active_i, dr_cs_n_i, st_rd_n_i} <= 3'h5;
			// a fresh word, so a path stuck on the static answer shows up
			resp <= $urandom;
			repeat (8) @(posedge clk_sys_i);
			#1;
			chk("dr_rdata", resp, dr_rdata_o);
			chk("st_wait_dr", 0, 32'(st_wait_o));
			stretch <= 0;
		end
		fpi(1, VERSION_QUERY_CMD, 0);
		fpi(0, 0, FPI_VERSION_RST);
		fpi(0, 0, 0);
		fpi(1, VERSION_QUERY_CMD, 0);
		fpi(1, 32'h0000_0005, 0);
		fpi(0, 0, 0);
		print_verdict();
	end
endmodule : ext_bus_pin_mux_tb
`default_nettype wire
